// [src/l2_ras_regs.vh]
// Purpose: constants for the second-level cache error detection, correction and poisoning block
// Assumes: 32-bit data words with 7 check bits, eight requesting cores
// Notes: offsets are byte addresses on the plain register port
`ifndef L2_RAS_REGS_VH
`define L2_RAS_REGS_VH

// register offsets
`define RA_CTRL 8'h00
`define RA_GESR 8'h04
`define RA_DIR 8'h08
`define RA_CESR_BASE 3'h1

// control: error_target_core_register
`define CTRL_CE_EN 0
`define CTRL_UE_EN 1
`define CTRL_CORE_LO 8
`define CTRL_CORE_HI 10
`define CTRL_MASK 32'h00000703
`define CTRL_RESET 32'h00000000

// global error_status_register fields
`define G_IO_CE 0
`define G_IO_UE 1
`define G_CORE_UE 2
`define G_TAG_CE 3
`define G_ST_CE 4
`define G_ST_UE 5
`define G_FB_CE 6
`define G_FB_UE 7
`define G_WB_CE 8
`define G_WB_UE 9
`define G_IO_WRITE_BUFFER_CE 10
`define G_IO_WRITE_BUFFER_UE 11
`define G_POISON 12
`define G_DIR_PAR 13
`define G_SYN_LO 16
`define G_SYN_HI 22

// per-core error_status_register fields
`define C_CE 0
`define C_ND 2
`define C_SYN_LO 8
`define C_SYN_HI 14

// directory status register fields
`define D_FATAL 8

// check sources
`define SRC_CORE 3'h0
`define SRC_IO 3'h1
`define SRC_TAG 3'h2
`define SRC_STATE 3'h3
`define SRC_FILL 3'h4
`define SRC_WB 3'h5
`define SRC_IO_WRITE_BUFFER 3'h6

// core request kinds
`define KIND_LOAD 2'h0
`define KIND_IFETCH 2'h1
`define KIND_ATOMIC 2'h2
`define KIND_STORE 2'h3

// return packet error code, bits 139:138 of the return packet
`define ERR_PKT_HI 139
`define ERR_PKT_LO 138
`define ERR_NONE 2'h0
`define ERR_CE 2'h1
`define ERR_UE 2'h2
`define ERR_ND 2'h3

// repair targets
`define FIX_DATA 2'h0
`define FIX_TAG 2'h1
`define FIX_STATE 2'h2

// check code geometry
`define DATA_W 32
`define ECC_W 7
`define SYN_POISON 7'h7F
`define HAM_LAST 38

// unprotected buffers and directory
`define MB_ENTRIES 32
`define FB_TAG_ENTRIES 8
`define BUF_TAG_W 40
`define DIR_W 32
`define DIR_PTR_W 6
`define DIR_LAST 6'h3F

`endif

// [src/secded32.v]
// Purpose: single-error-correct, double-error-detect code over one 32-bit word, with poison decode
// Assumes: check bits [5:0] are hamming positions, bit 6 is overall parity
// Notes: an all-ones syndrome means the word was stored with inverted check bits
`include "l2_ras_regs.vh"

module secded32 (
	// word under check
	input wire [31:0] data_in,
	input wire [6:0] check_in,
	// results
	output wire [6:0] gen_check,
	output reg [31:0] fixed_data,
	output wire [6:0] fixed_check,
	output wire [6:0] syndrome,
	output wire single_err,
	output wire multi_err,
	output wire poisoned
);

function [6:0] encode;
	input [31:0] d;
	integer p;
	integer k;
	integer i;
	reg [6:0] c;
	begin
		c = 7'h00;
		k = 0;
		for (p = 1; p <= `HAM_LAST; p = p + 1) begin
			if ((p & (p - 1)) != 0) begin
				for (i = 0; i < 6; i = i + 1) begin
					if (p[i])
						c[i] = c[i] ^ d[k];
				end
				k = k + 1;
			end
		end
		c[6] = (^d) ^ (^c[5:0]);
		encode = c;
	end
endfunction

integer p;
integer k;

assign gen_check = encode(data_in);
assign syndrome = {(^data_in) ^ (^check_in), gen_check[5:0] ^ check_in[5:0]};
// inverted check bits flip all six hamming bits and the overall bit, so a poisoned word lands on all ones
assign poisoned = (syndrome == `SYN_POISON);
// a single flip in a poisoned word clears the overall bit and so decodes as multi-bit, never as correctable
assign single_err = syndrome[6] & !poisoned & (syndrome[5:0] <= `HAM_LAST);
assign multi_err = (syndrome != 7'h00) & !poisoned & !single_err;
assign fixed_check = encode(fixed_data);

always @* begin
	fixed_data = data_in;
	k = 0;
	for (p = 1; p <= `HAM_LAST; p = p + 1) begin
		if ((p & (p - 1)) != 0) begin
			if (single_err && (syndrome[5:0] == p[5:0]))
				fixed_data[k] = ~data_in[k];
			k = k + 1;
		end
	end
end

endmodule

// [src/l2_ras_ecc_poison.v]
// Purpose: error check, correction, logging and trap requests for a shared second-level cache
// Assumes: one check request per cycle from the cache pipeline, all inputs on clk except rst_b and dbg_init_b
// Notes: outputs are registered, so every answer follows its request by one cycle
//
// The placing of the registers and the strobed register port were decided locally.
`include "l2_ras_regs.vh"

module l2_ras_ecc_poison (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire dbg_init_b,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// word check request
	input wire chk_valid,
	input wire [2:0] chk_source,
	input wire [1:0] chk_kind,
	input wire [2:0] chk_core,
	input wire [31:0] chk_data,
	input wire [6:0] chk_ecc,
	// memory return into the fill buffer
	input wire mret_valid,
	input wire [31:0] mret_data,
	input wire mret_ue,
	output reg fbw_valid,
	output reg [31:0] fbw_data,
	output reg [6:0] fbw_ecc,
	// directory background check
	input wire dir_store_issue,
	input wire [31:0] dir_entry,
	input wire dir_parity,
	output reg [5:0] dir_index,
	output reg dir_fatal,
	// core return
	output reg rsp_valid,
	output reg [2:0] rsp_core,
	output reg [31:0] rsp_data,
	output reg [1:0] rsp_err,
	// trap request
	output reg trap_valid,
	output reg [2:0] trap_core,
	output reg trap_precise,
	// array repair and replay
	output reg fix_valid,
	output reg [1:0] fix_target,
	output reg [31:0] fix_data,
	output reg [6:0] fix_ecc,
	output reg replay_req,
	// write toward memory
	output reg mem_wr_valid,
	output reg [31:0] mem_wr_data,
	output reg mem_wr_ue,
	// chip reset request
	output reg warm_reset_req
);

////////////////////////////////////////////////////////////////////////////////
// storage

reg [31:0] ctrl;
reg [31:0] gesr;
reg [31:0] core_esr [0:7];
reg dbg_meta;
reg dbg_sync;
integer n;

////////////////////////////////////////////////////////////////////////////////
// checkers

wire [31:0] c_data;
wire [6:0] c_fix_ecc;
wire [6:0] c_syn;
wire c_ce;
wire c_ue;
wire c_pois;
wire [6:0] f_gen;

// the same decoder serves every source; the source code picks the reaction
secded32 u_check (
	.data_in(chk_data),
	.check_in(chk_ecc),
	.gen_check(),
	.fixed_data(c_data),
	.fixed_check(c_fix_ecc),
	.syndrome(c_syn),
	.single_err(c_ce),
	.multi_err(c_ue),
	.poisoned(c_pois)
);

secded32 u_fill_enc (
	.data_in(mret_data),
	.check_in(7'h00),
	.gen_check(f_gen),
	.fixed_data(),
	.fixed_check(),
	.syndrome(),
	.single_err(),
	.multi_err(),
	.poisoned()
);

////////////////////////////////////////////////////////////////////////////////
// reaction to one checked word

wire [2:0] steer = ctrl[`CTRL_CORE_HI:`CTRL_CORE_LO];
wire ce_en = ctrl[`CTRL_CE_EN];
wire ue_en = ctrl[`CTRL_UE_EN];
wire is_store = (chk_kind == `KIND_STORE);
wire dir_bad = dir_store_issue & (^{dir_entry, dir_parity});

reg [31:0] g_set;
reg [31:0] c_set;
reg next_trap;
reg [2:0] next_trap_core;
reg next_precise;
reg next_rsp;
reg next_fix;
reg [1:0] next_fix_target;
reg [31:0] next_fix_data;
reg [6:0] next_fix_ecc;
reg next_replay;
reg next_mem_wr;
reg next_warm;
reg [1:0] err_code;

always @* begin
	g_set = 32'h00000000;
	c_set = 32'h00000000;
	next_trap = 1'b0;
	next_trap_core = steer;
	next_precise = 1'b0;
	next_rsp = 1'b0;
	next_fix = 1'b0;
	next_fix_target = `FIX_DATA;
	next_fix_data = c_data;
	next_fix_ecc = c_fix_ecc;
	next_replay = 1'b0;
	next_mem_wr = 1'b0;
	next_warm = 1'b0;
	if (c_pois)
		err_code = `ERR_ND;
	else if (c_ue)
		err_code = `ERR_UE;
	else if (c_ce)
		err_code = `ERR_CE;
	else
		err_code = `ERR_NONE;
	if (chk_valid) begin
		case (chk_source)
			`SRC_CORE: begin
				next_trap_core = chk_core;
				next_precise = !is_store;
				next_rsp = !is_store;
				if (c_ce) begin
					c_set[`C_CE] = 1'b1;
					next_trap = ce_en;
				end
				if (c_ue) begin
					g_set[`G_CORE_UE] = 1'b1;
					next_trap = ue_en;
				end
				if (c_pois) begin
					c_set[`C_ND] = 1'b1;
					g_set[`G_POISON] = 1'b1;
					next_trap = ue_en;
				end
			end
			`SRC_IO: begin
				if (c_ce) begin
					g_set[`G_IO_CE] = 1'b1;
					next_trap = ce_en;
					next_fix = 1'b1;
				end
				if (c_ue) begin
					g_set[`G_IO_UE] = 1'b1;
					next_trap = ue_en;
				end
				if (c_pois) begin
					g_set[`G_POISON] = 1'b1;
					next_trap = ue_en;
				end
			end
			`SRC_TAG: begin
				// double flips in a tag are not looked for
				if (c_ce) begin
					g_set[`G_TAG_CE] = 1'b1;
					next_trap = ce_en;
					next_fix = 1'b1;
					next_fix_target = `FIX_TAG;
					next_replay = 1'b1;
				end
			end
			`SRC_STATE: begin
				if (c_ce) begin
					g_set[`G_ST_CE] = 1'b1;
					next_trap = ce_en;
					next_fix = 1'b1;
					next_fix_target = `FIX_STATE;
					next_replay = 1'b1;
				end
				if (c_ue || c_pois) begin
					g_set[`G_ST_UE] = 1'b1;
					next_warm = 1'b1;
				end
			end
			`SRC_FILL: begin
				// fill always writes the array; poisoned words keep their inverted check bits
				next_fix = 1'b1;
				if (!c_ce) begin
					next_fix_data = chk_data;
					next_fix_ecc = chk_ecc;
				end
				if (c_ce) begin
					g_set[`G_FB_CE] = 1'b1;
					next_trap = ce_en;
				end
				if (c_ue || c_pois) begin
					g_set[`G_FB_UE] = 1'b1;
					next_trap = ue_en;
				end
			end
			`SRC_WB, `SRC_IO_WRITE_BUFFER: begin
				next_mem_wr = 1'b1;
				if (c_ce) begin
					g_set[(chk_source == `SRC_WB) ? `G_WB_CE : `G_IO_WRITE_BUFFER_CE] = 1'b1;
					next_trap = ce_en;
				end
				if (c_ue || c_pois) begin
					g_set[(chk_source == `SRC_WB) ? `G_WB_UE : `G_IO_WRITE_BUFFER_UE] = 1'b1;
					next_trap = ue_en;
				end
			end
			default: begin
				next_trap = 1'b0;
			end
		endcase
	end
	if (dir_bad)
		g_set[`G_DIR_PAR] = 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// register port

wire wr_ctrl = reg_wr && (reg_addr == `RA_CTRL);
wire wr_gesr = reg_wr && (reg_addr == `RA_GESR);
wire wr_dir = reg_wr && (reg_addr == `RA_DIR);
wire cesr_hit = (reg_addr[7:5] == `RA_CESR_BASE) && (reg_addr[1:0] == 2'h0);
wire [2:0] cesr_sel = reg_addr[4:2];

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		reg_rdata <= 32'h00000000;
	end else if (reg_rd) begin
		if (reg_addr == `RA_CTRL)
			reg_rdata <= ctrl;
		else if (reg_addr == `RA_GESR)
			reg_rdata <= gesr;
		else if (reg_addr == `RA_DIR)
			reg_rdata <= {16'h0000, 7'h00, dir_fatal, 2'h0, dir_index};
		else if (cesr_hit)
			reg_rdata <= core_esr[cesr_sel];
		else
			reg_rdata <= 32'h00000000;
	end else begin
		reg_rdata <= 32'h00000000;
	end
end

// status bits clear by writing one; a new event in the same cycle wins over the clear
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		ctrl <= `CTRL_RESET;
		gesr <= 32'h00000000;
		for (n = 0; n < 8; n = n + 1)
			core_esr[n] <= 32'h00000000;
	end else begin
		if (wr_ctrl)
			ctrl <= reg_wdata & `CTRL_MASK;
		gesr <= (gesr & ~(wr_gesr ? reg_wdata : 32'h00000000)) | g_set;
		if (g_set[`G_DIR_PAR - 1:0] != 13'h0000)
			gesr[`G_SYN_HI:`G_SYN_LO] <= c_syn;
		for (n = 0; n < 8; n = n + 1) begin
			if (cesr_hit && reg_wr && (cesr_sel == n[2:0]))
				core_esr[n] <= (core_esr[n] & ~reg_wdata) | ((chk_core == n[2:0]) ? c_set : 32'h00000000);
			else if (chk_core == n[2:0])
				core_esr[n] <= core_esr[n] | c_set;
			if ((chk_core == n[2:0]) && (c_set != 32'h00000000))
				core_esr[n][`C_SYN_HI:`C_SYN_LO] <= c_syn;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// directory background parity

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		dbg_meta <= 1'b1;
		dbg_sync <= 1'b1;
	end else begin
		dbg_meta <= dbg_init_b;
		dbg_sync <= dbg_meta;
	end
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		dir_index <= 6'h00;
		dir_fatal <= 1'b0;
	end else begin
		if (!dbg_sync)
			dir_index <= 6'h00;
		else if (dir_store_issue)
			dir_index <= (dir_index == `DIR_LAST) ? 6'h00 : dir_index + 6'h01;
		if (dir_bad)
			dir_fatal <= 1'b1;
		else if (wr_dir && reg_wdata[`D_FATAL])
			dir_fatal <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// registered answers

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		fbw_valid <= 1'b0;
		fbw_data <= 32'h00000000;
		fbw_ecc <= 7'h00;
		rsp_valid <= 1'b0;
		rsp_core <= 3'h0;
		rsp_data <= 32'h00000000;
		rsp_err <= `ERR_NONE;
		trap_valid <= 1'b0;
		trap_core <= 3'h0;
		trap_precise <= 1'b0;
		fix_valid <= 1'b0;
		fix_target <= `FIX_DATA;
		fix_data <= 32'h00000000;
		fix_ecc <= 7'h00;
		replay_req <= 1'b0;
		mem_wr_valid <= 1'b0;
		mem_wr_data <= 32'h00000000;
		mem_wr_ue <= 1'b0;
		warm_reset_req <= 1'b0;
	end else begin
		fbw_valid <= mret_valid;
		fbw_data <= mret_data;
		fbw_ecc <= mret_ue ? ~f_gen : f_gen;
		rsp_valid <= next_rsp;
		rsp_core <= chk_core;
		rsp_data <= c_data;
		rsp_err <= err_code;
		trap_valid <= next_trap;
		trap_core <= next_trap_core;
		trap_precise <= next_precise;
		fix_valid <= next_fix;
		fix_target <= next_fix_target;
		fix_data <= next_fix_data;
		fix_ecc <= next_fix_ecc;
		replay_req <= next_replay;
		mem_wr_valid <= next_mem_wr;
		mem_wr_data <= c_data;
		mem_wr_ue <= c_ue | c_pois;
		// once raised the chip is expected to reset this block
		if (next_warm)
			warm_reset_req <= 1'b1;
	end
end

// buffer tags (miss buffer, fill, writeback and I/O write) have no check path here

endmodule

// [testbench/l2_ras_ecc_poison_sva.sv]
// Purpose: port-level checks on the cache error check, logging and directory scan block
// Assumes: one clock, rst_b asynchronous active low, dbg_init_b synchronised inside the block
// Notes: debug init is taken as settled only after four steady samples
`include "l2_ras_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module l2_ras_ecc_poison_chk (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire dbg_init_b,
	// requests
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire chk_valid,
	input wire [2:0] chk_source,
	input wire [1:0] chk_kind,
	input wire mret_valid,
	input wire dir_store_issue,
	input wire [31:0] dir_entry,
	input wire dir_parity,
	// answers
	input wire rsp_valid,
	input wire trap_valid,
	input wire fbw_valid,
	input wire mem_wr_valid,
	input wire [5:0] dir_index,
	input wire dir_fatal,
	input wire warm_reset_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_load_rsp;
		chk_valid && chk_source == `SRC_CORE && chk_kind != `KIND_STORE |=> rsp_valid;
	endproperty
	a_load_rsp: assert property (p_load_rsp) else $error("no return for core read");
	property p_store_quiet;
		chk_valid && chk_source == `SRC_CORE && chk_kind == `KIND_STORE |=> !rsp_valid;
	endproperty
	a_store_quiet: assert property (p_store_quiet) else $error("return sent for store");
	property p_fill_write;
		mret_valid |=> fbw_valid;
	endproperty
	a_fill_write: assert property (p_fill_write) else $error("memory return not written");
	property p_wb_out;
		chk_valid && (chk_source == `SRC_WB || chk_source == `SRC_IO_WRITE_BUFFER) |=> mem_wr_valid;
	endproperty
	a_wb_out: assert property (p_wb_out) else $error("buffer word not sent to memory");
	property p_trap_cause;
		trap_valid |-> $past(chk_valid);
	endproperty
	a_trap_cause: assert property (p_trap_cause) else $error("trap without a check");
	property p_dir_step;
		dbg_init_b [*4] ##0 dir_store_issue |=> dir_index == $past(dir_index) + 6'h01;
	endproperty
	a_dir_step: assert property (p_dir_step) else $error("scan pointer did not step");
	property p_dir_hold;
		dbg_init_b [*4] ##0 !dir_store_issue |=> $stable(dir_index);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("scan pointer moved idle");
	property p_init_zero;
		(!dbg_init_b) [*4] |=> dir_index == 6'h00;
	endproperty
	a_init_zero: assert property (p_init_zero) else $error("debug init left pointer");
	property p_parity_fatal;
		dir_store_issue && (^{dir_entry, dir_parity}) |=> dir_fatal;
	endproperty
	a_parity_fatal: assert property (p_parity_fatal) else $error("parity fault missed");
	property p_fatal_sticky;
		dir_fatal && !(reg_wr && reg_addr == `RA_DIR) |=> dir_fatal;
	endproperty
	a_fatal_sticky: assert property (p_fatal_sticky) else $error("fatal flag dropped");
	property p_warm_sticky;
		warm_reset_req |=> warm_reset_req;
	endproperty
	a_warm_sticky: assert property (p_warm_sticky) else $error("warm reset dropped");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind l2_ras_ecc_poison l2_ras_ecc_poison_chk u_chk (.clk(clk), .rst_b(rst_b), .dbg_init_b(dbg_init_b),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .chk_valid(chk_valid), .chk_source(chk_source), .chk_kind(chk_kind),
	.mret_valid(mret_valid), .dir_store_issue(dir_store_issue), .dir_entry(dir_entry), .dir_parity(dir_parity),
	.rsp_valid(rsp_valid), .trap_valid(trap_valid), .fbw_valid(fbw_valid), .mem_wr_valid(mem_wr_valid),
	.dir_index(dir_index), .dir_fatal(dir_fatal), .warm_reset_req(warm_reset_req));

// [testbench/l2_dir_model.sv]
// Purpose: directory store seen by the background parity scan
// Assumes: entry at the scan pointer is presented in the same cycle
// Notes: one slot can be spoiled on command to reach the fatal path
module l2_dir_model (
	// lookup
	input wire [5:0] dir_index,
	// fault control
	input wire bad_en,
	input wire [5:0] bad_index,
	// entry
	output logic [31:0] dir_entry,
	output logic dir_parity
);
	timeunit 1ns;
	timeprecision 1ps;
	// contents follow the index so a stale pointer shows up as a wrong entry
	assign dir_entry = {dir_index, 2'h2, ~dir_index, 18'h2A5C3};
	assign dir_parity = (^dir_entry) ^ (bad_en && dir_index == bad_index);
endmodule

// [testbench/tb_l2_ras_ecc_poison.sv]
// Purpose: self-checking bench for cache error check, poisoning and directory scan
// Assumes: answers stand just after the taking edge
// Notes: check codes are rebuilt here from the code rules, not from the design
`include "l2_ras_regs.vh"
module tb_l2_ras_ecc_poison;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, dbg_init_b, reg_wr, reg_rd, chk_valid, mret_valid, mret_ue, dir_store_issue, dir_parity;
	logic fbw_valid, dir_fatal, rsp_valid, trap_valid, trap_precise, fix_valid, replay_req, mem_wr_valid;
	logic mem_wr_ue, warm_reset_req, bad_en;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, chk_data, mret_data, dir_entry, fbw_data, rsp_data, fix_data, mem_wr_data;
	logic [31:0] v, d;
	logic [2:0] chk_source, chk_core, rsp_core, trap_core;
	logic [1:0] chk_kind, rsp_err, fix_target;
	logic [6:0] chk_ecc, fbw_ecc, fix_ecc, e;
	logic [5:0] dir_index, bad_index;
	int fails, n_tests;
	l2_ras_ecc_poison DUT (.clk(clk), .rst_b(rst_b), .dbg_init_b(dbg_init_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chk_valid(chk_valid),
		.chk_source(chk_source), .chk_kind(chk_kind), .chk_core(chk_core), .chk_data(chk_data), .chk_ecc(chk_ecc),
		.mret_valid(mret_valid), .mret_data(mret_data), .mret_ue(mret_ue), .fbw_valid(fbw_valid),
		.fbw_data(fbw_data), .fbw_ecc(fbw_ecc), .dir_store_issue(dir_store_issue), .dir_entry(dir_entry),
		.dir_parity(dir_parity), .dir_index(dir_index), .dir_fatal(dir_fatal), .rsp_valid(rsp_valid),
		.rsp_core(rsp_core), .rsp_data(rsp_data), .rsp_err(rsp_err), .trap_valid(trap_valid),
		.trap_core(trap_core), .trap_precise(trap_precise), .fix_valid(fix_valid), .fix_target(fix_target),
		.fix_data(fix_data), .fix_ecc(fix_ecc), .replay_req(replay_req), .mem_wr_valid(mem_wr_valid),
		.mem_wr_data(mem_wr_data), .mem_wr_ue(mem_wr_ue), .warm_reset_req(warm_reset_req));
	l2_dir_model u_dir (.dir_index(dir_index), .bad_en(bad_en), .bad_index(bad_index), .dir_entry(dir_entry),
		.dir_parity(dir_parity));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [6:0] enc(input logic [31:0] w);
		int k;
		logic [6:0] c;
		c = 7'h00;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if (p & (p - 1)) begin
				if (w[k]) c[5:0] = c[5:0] ^ p[5:0];
				k++;
			end
		end
		c[6] = ^{w, c[5:0]};
		return c;
	endfunction
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk(input logic [2:0] s, input logic [1:0] k, input logic [2:0] c, input logic [31:0] w,
		input logic [6:0] x);
		@(posedge clk);
		chk_valid <= 1'b1;
		chk_source <= s;
		chk_kind <= k;
		chk_core <= c;
		chk_data <= w;
		chk_ecc <= x;
		@(posedge clk);
		chk_valid <= 1'b0;
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_core();
		wr(`RA_CTRL, 32'h00000503);
		chk(`SRC_CORE, `KIND_LOAD, 3'h3, d ^ 32'h00000010, e);
		cmp({rsp_valid, rsp_core, rsp_err, rsp_data}, {1'b1, 3'h3, `ERR_CE, d});
		cmp({trap_valid, trap_core, trap_precise}, 5'h17);
		rd(8'h2C);
		cmp(v[`C_CE], 1'b1);
		for (int k = 0; k < 4; k++) begin
			chk(`SRC_CORE, k[1:0], 3'h6, d ^ 32'h00000003, e);
			cmp({trap_valid, trap_core, trap_precise}, {4'hE, k != 3});
			if (k != 3) cmp(rsp_err, `ERR_UE);
		end
		rd(`RA_GESR);
		cmp(v[`G_CORE_UE], 1'b1);
		$display("core data test done");
	endtask
	task automatic t_io();
		chk(`SRC_IO, `KIND_LOAD, 3'h1, d ^ 32'h00000001, e);
		cmp({fix_valid, fix_target, fix_data, fix_ecc}, {1'b1, `FIX_DATA, d, e});
		cmp({trap_valid, trap_core, trap_precise}, 5'h1A);
		chk(`SRC_IO, `KIND_STORE, 3'h1, d ^ 32'h00000003, e);
		cmp({trap_valid, trap_core, trap_precise}, 5'h1A);
		rd(`RA_GESR);
		cmp(v[1:0], 2'h3);
		$display("io data test done");
	endtask
	task automatic t_poison();
		for (int u = 0; u < 2; u++) begin
			@(posedge clk);
			mret_valid <= 1'b1;
			mret_data <= d;
			mret_ue <= u[0];
			@(posedge clk);
			mret_valid <= 1'b0;
			#1 cmp({fbw_valid, fbw_data, fbw_ecc}, {1'b1, d, u ? ~e : e});
		end
		chk(`SRC_CORE, `KIND_LOAD, 3'h2, d, ~e);
		cmp(rsp_err, `ERR_ND);
		rd(8'h28);
		cmp(v[`C_ND], 1'b1);
		chk(`SRC_CORE, `KIND_LOAD, 3'h2, d ^ 32'h00000004, ~e);
		cmp(rsp_err, `ERR_UE);
		chk(`SRC_CORE, `KIND_IFETCH, 3'h2, d, ~e ^ 7'h01);
		cmp(rsp_err, `ERR_UE);
		$display("poison test done");
	endtask
	task automatic t_bufs();
		for (int s = 4; s < 7; s++) begin
			chk(s[2:0], `KIND_LOAD, 3'h0, d ^ 32'h80000000, e);
			cmp({trap_valid, trap_core, trap_precise}, 5'h1A);
			if (s == 4) cmp({fix_valid, fix_data, fix_ecc}, {1'b1, d, e});
			else cmp({mem_wr_valid, mem_wr_data, mem_wr_ue}, {1'b1, d, 1'b0});
		end
		chk(`SRC_IO_WRITE_BUFFER, `KIND_LOAD, 3'h0, d ^ 32'h00000003, e);
		cmp(mem_wr_ue, 1'b1);
		chk(`SRC_TAG, `KIND_LOAD, 3'h0, d ^ 32'h00000100, e);
		cmp({fix_valid, fix_target, fix_data, replay_req}, {1'b1, `FIX_TAG, d, 1'b1});
		chk(`SRC_TAG, `KIND_LOAD, 3'h0, d ^ 32'h00000003, e);
		cmp(trap_valid, 1'b0);
		$display("buffer and tag test done");
	endtask
	task automatic t_enable();
		wr(`RA_CTRL, 32'hFFFFF500);
		rd(`RA_CTRL);
		cmp(v, 32'h00000500);
		wr(8'h2C, 32'h00000001);
		rd(8'h2C);
		cmp(v[`C_CE], 1'b0);
		chk(`SRC_CORE, `KIND_LOAD, 3'h3, d ^ 32'h00000020, e);
		cmp(trap_valid, 1'b0);
		rd(8'h2C);
		cmp(v[`C_CE], 1'b1);
		rd(8'hF0);
		cmp(v, 32'h00000000);
		wr(`RA_CTRL, 32'h00000503);
		$display("enable test done");
	endtask
	task automatic t_dir();
		@(posedge clk);
		bad_index <= 6'h03;
		bad_en <= 1'b1;
		dir_store_issue <= 1'b1;
		repeat (4) @(posedge clk);
		dir_store_issue <= 1'b0;
		#1 cmp({dir_index, dir_fatal}, {6'h04, 1'b1});
		rd(`RA_DIR);
		cmp({v[`D_FATAL], v[5:0]}, 7'h44);
		rd(`RA_GESR);
		cmp(v[`G_DIR_PAR], 1'b1);
		// pointer now stands away from zero, so the init has something to undo
		@(posedge clk);
		dbg_init_b <= 1'b0;
		repeat (4) @(posedge clk);
		dbg_init_b <= 1'b1;
		#1 cmp(dir_index, 6'h00);
		$display("directory test done");
	endtask
	task automatic t_state();
		chk(`SRC_STATE, `KIND_LOAD, 3'h0, d ^ 32'h00010000, e);
		cmp({fix_valid, fix_target, replay_req, warm_reset_req}, {1'b1, `FIX_STATE, 2'h2});
		chk(`SRC_STATE, `KIND_LOAD, 3'h0, d ^ 32'h00000003, e);
		rd(`RA_GESR);
		cmp({warm_reset_req, v[`G_ST_UE]}, 2'h3);
		do_reset();
		rd(`RA_CTRL);
		cmp({warm_reset_req, v}, {1'b0, `CTRL_RESET});
		$display("line state test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{rst_b, reg_wr, reg_rd, chk_valid, mret_valid, mret_ue, dir_store_issue, bad_en} = 8'h00;
		{reg_addr, reg_wdata, chk_data, mret_data, chk_ecc} = '0;
		{chk_source, chk_kind, chk_core, bad_index} = '0;
		dbg_init_b = 1'b1;
		fails = 0;
		n_tests = 0;
		d = 32'h1234ABCD;
		e = enc(d);
		do_reset();
		t_core();
		t_io();
		t_poison();
		t_bufs();
		t_enable();
		t_dir();
		t_state();
		results();
	end
	// hang guard
	initial begin
		#1ms;
		fails++;
		results();
	end
endmodule
